// ### hw/boot_link_if.sv
// Purpose: Link between the boot loader and the host or boot memory side
// Assumes: One clock; every signal driven from a flip-flop of its owner
// Notes:   Active-low lines end in _n
`timescale 1ns/100ps
interface boot_link_if;
	import boot_pkg::*;
	logic        rom_boot_select_pin;
	logic        external_interrupt_two_n;
	logic        host_interrupt_line_n;
	logic        host_line_clear;
	logic [15:0] mem_addr;
	logic        mem_rd;
	logic        io_space_strobe_n;
	logic [15:0] mem_rdata;
	logic        mem_ack;
	logic [15:0] pm_addr;
	logic [15:0] pm_wdata;
	logic        pm_we;
	logic        boot_done;
	logic [15:0] branch_addr;
	mode_t       boot_mode;

	modport loader (
		input  rom_boot_select_pin, external_interrupt_two_n, host_line_clear, mem_rdata, mem_ack,
		output host_interrupt_line_n, mem_addr, mem_rd, io_space_strobe_n, pm_addr, pm_wdata, pm_we,
		output boot_done, branch_addr, boot_mode
	);
	modport system (
		output rom_boot_select_pin, external_interrupt_two_n, host_line_clear, mem_rdata, mem_ack,
		input  host_interrupt_line_n, mem_addr, mem_rd, io_space_strobe_n, pm_addr, pm_wdata, pm_we,
		input  boot_done, branch_addr, boot_mode
	);
endinterface

// ### hw/boot_mode_loader.sv
// Purpose: Reset-time boot loader: init, host boot test, select decode, parallel copy
// Assumes: Memory answers each mem_rd pulse with one mem_ack pulse and data
// Notes:   I/O, serial and handshake transfers are decoded only, then the loader halts
// Overview of operation
// - Select pin low at reset enters ROM FF80h
// - Mask interrupts, map on-chip RAM via overlay
// - Seven wait states, 4K banks, one latency
// - Read select word at I/O FFFFh
// - Ignore select bits above the low eight
// - Low bits 00: 1000 I/O16, 1100 I/O8
// - Buffered serial port patterns choose width, direction
// - Time-slot serial patterns choose width, outputs
// - 01 parallel 8, 11 warm, else 16
// - Host line low, wait 20, test flag
// - Flag set jumps 1000h, else read select
// - System ties or pulses interrupt two early
// - Host loads host RAM before reset release
// - Shared access select held one throughout boot
// - Host line stays low until host clears
// - Source upper six bits from select page
// - Sixteen-bit reads, source increments by one
// - First two words are destination and length
// - Ten cycles between read and write
// - Length into repeat counter, copy until exhausted
// - Branch to destination after copy
// - Byte mode pairs high byte then low
// - Byte mode uses low eight data lines
`timescale 1ns/100ps
module boot_mode_loader (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	boot_link_if.loader      link,
	output logic             global_int_mask,
	output logic             ram_overlay,
	output logic [15:0]      wait_state_cfg,
	output logic [15:0]      bank_cfg,
	output logic             shared_access_select,
	output logic             serial_word16,
	output logic             serial_clk_out,
	output logic             serial_port_tdm
);
	import boot_pkg::*;

	typedef enum logic [3:0] {
		S_START, S_INIT, S_HOST_INTERRUPT_LINE_WAIT, S_TEST, S_SEL_RD, S_SEL_WAIT, S_DECODE,
		S_RD, S_RD_WAIT, S_GAP, S_WR, S_BRANCH, S_HALT
	} state_t;

	state_t      state_q;
	mode_t       mode_q;
	logic [4:0]  wait_cnt_q;
	logic [3:0]  gap_cnt_q;
	logic        external_interrupt_two_flag_q;
	logic        host_interrupt_line_n_q;
	logic [7:0]  sel_q;
	logic [15:0] src_q;
	logic [15:0] dst_q;
	logic [15:0] entry_q;
	logic [15:0] block_repeat_counter_q;
	logic [15:0] word_q;
	logic [7:0]  hi_byte_q;
	logic        byte_mode_q;
	logic        lo_next_q;
	logic [1:0]  word_idx_q;
	logic [15:0] addr_q;
	logic        rd_q;
	logic        io_n_q;
	logic [15:0] pm_addr_q;
	logic [15:0] pm_wdata_q;
	logic        pm_we_q;
	logic        done_q;
	logic [15:0] pc_q;
	logic [15:0] word_in;

	// Byte mode glues the held high byte to the low data lines
	assign word_in = byte_mode_q ? {hi_byte_q, link.mem_rdata[7:0]} : link.mem_rdata;

	assign link.host_interrupt_line_n = host_interrupt_line_n_q;
	assign link.mem_addr              = addr_q;
	assign link.mem_rd                = rd_q;
	assign link.io_space_strobe_n     = io_n_q;
	assign link.pm_addr               = pm_addr_q;
	assign link.pm_wdata              = pm_wdata_q;
	assign link.pm_we                 = pm_we_q;
	assign link.boot_done             = done_q;
	assign link.branch_addr           = pc_q;
	assign link.boot_mode             = mode_q;

	// Interrupt two flag; cleared only by the test, so a late event still sets it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			external_interrupt_two_flag_q <= 1'b0;
		end else if (!link.external_interrupt_two_n) begin
			external_interrupt_two_flag_q <= 1'b1;
		end else if (state_q == S_TEST) begin
			external_interrupt_two_flag_q <= 1'b0;
		end
	end

	// Host line: low from init until the host writes its clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			host_interrupt_line_n_q <= 1'b1;
		end else if (state_q == S_INIT) begin
			host_interrupt_line_n_q <= 1'b0;
		end else if (link.host_line_clear) begin
			host_interrupt_line_n_q <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pm_we_q <= 1'b0;
		end else begin
			pm_we_q <= (state_q == S_WR);
		end
	end

	// Processor status set up once, before any transfer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			global_int_mask      <= 1'b0;
			ram_overlay          <= 1'b0;
			wait_state_cfg       <= '0;
			bank_cfg             <= '0;
			shared_access_select <= 1'b0;
		end else if (state_q == S_INIT) begin
			global_int_mask      <= 1'b1;
			ram_overlay          <= 1'b1;
			wait_state_cfg       <= WAIT_STATE_CFG;
			bank_cfg             <= BANK_CFG;
			shared_access_select <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q                <= S_START;
			mode_q                 <= MODE_NONE;
			wait_cnt_q             <= '0;
			gap_cnt_q              <= '0;
			sel_q                  <= '0;
			src_q                  <= '0;
			dst_q                  <= '0;
			entry_q                <= '0;
			block_repeat_counter_q <= '0;
			word_q                 <= '0;
			hi_byte_q              <= '0;
			byte_mode_q            <= 1'b0;
			lo_next_q              <= 1'b0;
			word_idx_q             <= '0;
			addr_q                 <= '0;
			rd_q                   <= 1'b0;
			io_n_q                 <= 1'b1;
			pm_addr_q              <= '0;
			pm_wdata_q             <= '0;
			done_q                 <= 1'b0;
			pc_q                   <= '0;
			serial_word16          <= 1'b0;
			serial_clk_out         <= 1'b0;
			serial_port_tdm        <= 1'b0;
		end else begin
			rd_q <= 1'b0;
			case (state_q)
				// Pin is caught on the first edge after release, not by the reset itself
				S_START: begin
					if (!link.rom_boot_select_pin) begin
						pc_q    <= ROM_BOOT_ENTRY;
						state_q <= S_INIT;
					end else begin
						pc_q    <= EXT_RESET_VECTOR;
						mode_q  <= MODE_EXT;
						done_q  <= 1'b1;
						state_q <= S_HALT;
					end
				end
				S_INIT: begin
					wait_cnt_q <= HOST_INTERRUPT_LINE_WAIT_CYC - 5'd1;
					state_q    <= S_HOST_INTERRUPT_LINE_WAIT;
				end
				S_HOST_INTERRUPT_LINE_WAIT: begin
					wait_cnt_q <= wait_cnt_q - 5'd1;
					if (wait_cnt_q == 5'd0) begin
						state_q <= S_TEST;
					end
				end
				// Relies on the system raising interrupt two in time
				S_TEST: begin
					if (external_interrupt_two_flag_q) begin
						pc_q    <= HOST_RAM_START;
						mode_q  <= MODE_HOST;
						done_q  <= 1'b1;
						state_q <= S_HALT;
					end else begin
						state_q <= S_SEL_RD;
					end
				end
				S_SEL_RD: begin
					addr_q  <= SELECT_PORT;
					io_n_q  <= 1'b0;
					rd_q    <= 1'b1;
					state_q <= S_SEL_WAIT;
				end
				S_SEL_WAIT: begin
					if (link.mem_ack) begin
						io_n_q  <= 1'b1;
						sel_q   <= link.mem_rdata[7:0];
						state_q <= S_DECODE;
					end
				end
				S_DECODE: begin
					src_q       <= {sel_q[7:2], SRC_LOW_ZERO};
					byte_mode_q <= (sel_q[1:0] == SEL_LOW_PAR8);
					lo_next_q   <= 1'b0;
					word_idx_q  <= '0;
					done_q      <= 1'b1;
					state_q     <= S_HALT;
					serial_word16   <= sel_q[2];
					serial_clk_out  <= !sel_q[4];
					serial_port_tdm <= sel_q[5];
					if (sel_q[1:0] == SEL_LOW_IO && sel_q[3:0] == SEL_IO16) begin
						mode_q <= MODE_IO16;
					end else if (sel_q[1:0] == SEL_LOW_IO && sel_q[3:0] == SEL_IO8) begin
						mode_q <= MODE_IO8;
					end else if (sel_q[5:0] == SEL_BSP8_OUT) begin
						mode_q <= MODE_BSP8_OUT;
					end else if (sel_q[5:0] == SEL_BSP16_OUT) begin
						mode_q <= MODE_BSP16_OUT;
					end else if (sel_q[5:0] == SEL_BSP8_IN) begin
						mode_q <= MODE_BSP8_IN;
					end else if (sel_q[5:0] == SEL_BSP16_IN) begin
						mode_q <= MODE_BSP16_IN;
					end else if (sel_q[5:0] == SEL_TDM8_OUT) begin
						mode_q <= MODE_TDM8_OUT;
					end else if (sel_q[5:0] == SEL_TDM16_OUT) begin
						mode_q <= MODE_TDM16_OUT;
					end else if (sel_q[1:0] == SEL_LOW_WARM) begin
						mode_q <= MODE_WARM;
						pc_q   <= {sel_q[7:2], SRC_LOW_ZERO};
					end else begin
						mode_q  <= (sel_q[1:0] == SEL_LOW_PAR8) ? MODE_PAR8 : MODE_PAR16;
						done_q  <= 1'b0;
						state_q <= S_RD;
					end
				end
				S_RD: begin
					addr_q  <= src_q;
					rd_q    <= 1'b1;
					src_q   <= src_q + 16'd1;
					state_q <= S_RD_WAIT;
				end
				S_RD_WAIT: begin
					if (link.mem_ack) begin
						if (byte_mode_q && !lo_next_q) begin
							hi_byte_q <= link.mem_rdata[7:0];
							lo_next_q <= 1'b1;
							state_q   <= S_RD;
						end else begin
							lo_next_q <= 1'b0;
							case (word_idx_q)
								2'd0: begin
									dst_q      <= word_in;
									entry_q    <= word_in;
									word_idx_q <= 2'd1;
									state_q    <= S_RD;
								end
								2'd1: begin
									block_repeat_counter_q <= word_in;
									word_idx_q             <= 2'd2;
									state_q                <= S_RD;
								end
								default: begin
									word_q    <= word_in;
									gap_cnt_q <= COPY_GAP_CYC - 4'd1;
									state_q   <= S_GAP;
								end
							endcase
						end
					end
				end
				// Gives the source memory time to release the bus before the write
				S_GAP: begin
					gap_cnt_q <= gap_cnt_q - 4'd1;
					if (gap_cnt_q == 4'd0) begin
						state_q <= S_WR;
					end
				end
				S_WR: begin
					pm_addr_q  <= dst_q;
					pm_wdata_q <= word_q;
					dst_q      <= dst_q + 16'd1;
					if (block_repeat_counter_q == 16'd0) begin
						state_q <= S_BRANCH;
					end else begin
						block_repeat_counter_q <= block_repeat_counter_q - 16'd1;
						state_q                <= S_RD;
					end
				end
				S_BRANCH: begin
					pc_q    <= entry_q;
					done_q  <= 1'b1;
					state_q <= S_HALT;
				end
				S_HALT: begin
					state_q <= S_HALT;
				end
				default: begin
					state_q <= S_HALT;
				end
			endcase
		end
	end
endmodule

// ### hw/boot_pkg.sv
// Purpose: Shared constants and types for the boot loader and its system end
// Assumes: 16-bit processor addresses and data, 32-bit AHB-Lite on the system end
// Notes:   Loader and system end both import this package
package boot_pkg;
	localparam logic [15:0] ROM_BOOT_ENTRY   = 16'hff80;
	localparam logic [15:0] EXT_RESET_VECTOR = 16'h0000;
	localparam logic [15:0] HOST_RAM_START   = 16'h1000;
	localparam logic [15:0] SELECT_PORT      = 16'hffff;
	localparam logic [15:0] WAIT_STATE_CFG   = 16'h7fff;
	localparam logic [15:0] BANK_CFG         = 16'hf800;
	localparam logic [9:0]  SRC_LOW_ZERO     = 10'h000;
	localparam logic [4:0]  HOST_INTERRUPT_LINE_WAIT_CYC    = 5'd20;
	localparam logic [3:0]  COPY_GAP_CYC     = 4'd10;

	// Select word fields and patterns
	localparam logic [1:0] SEL_LOW_IO   = 2'b00;
	localparam logic [1:0] SEL_LOW_PAR8 = 2'b01;
	localparam logic [1:0] SEL_LOW_WARM = 2'b11;
	localparam logic [3:0] SEL_IO16     = 4'h8;
	localparam logic [3:0] SEL_IO8      = 4'hc;
	localparam logic [5:0] SEL_BSP8_OUT  = 6'h00;
	localparam logic [5:0] SEL_BSP16_OUT = 6'h04;
	localparam logic [5:0] SEL_BSP8_IN   = 6'h10;
	localparam logic [5:0] SEL_BSP16_IN  = 6'h14;
	localparam logic [5:0] SEL_TDM8_OUT  = 6'h20;
	localparam logic [5:0] SEL_TDM16_OUT = 6'h24;

	// System end register map (byte offsets on haddr[11:0])
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_SELECT   = 12'h008;
	localparam logic [11:0] REG_BRANCH   = 12'h00c;
	localparam logic [11:0] REG_PM_LAST  = 12'h010;
	localparam logic [11:0] REG_PM_COUNT = 12'h014;
	localparam logic [11:0] IMAGE_BASE   = 12'h100;
	localparam logic [11:0] IMAGE_MASK   = 12'hf00;
	localparam int          IMAGE_DEPTH  = 64;
	localparam int CTRL_PIN   = 0;
	localparam int CTRL_EXTERNAL_INTERRUPT_TWO  = 1;
	localparam int CTRL_CLEAR = 2;
	localparam int CTRL_TIE   = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	typedef enum logic [3:0] {
		MODE_NONE, MODE_HOST, MODE_IO16, MODE_IO8,
		MODE_BSP8_OUT, MODE_BSP16_OUT, MODE_BSP8_IN, MODE_BSP16_IN,
		MODE_TDM8_OUT, MODE_TDM16_OUT, MODE_PAR8, MODE_PAR16,
		MODE_WARM, MODE_EXT
	} mode_t;
endpackage

// ### hw/boot_system_end.sv
// Purpose: System end of the boot link: boot image, select word, host control, AHB-Lite slave
// Assumes: Single word AHB transfers; zero wait states
// Notes:   Host RAM download is assumed done before reset release
`timescale 1ns/100ps
module boot_system_end (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	boot_link_if.system      link
);
	import boot_pkg::*;

	logic [15:0] image_q [IMAGE_DEPTH];
	logic [3:0]  ctrl_q;
	logic [7:0]  select_q;
	logic [31:0] pm_last_q;
	logic [15:0] pm_count_q;
	logic        wr_pend_q;
	logic [11:0] wr_addr_q;
	logic        clear_q;
	logic        external_interrupt_two_n_q;
	logic        ack_q;
	logic [15:0] rdata_q;
	logic        addr_ok;
	logic [31:0] rd_mux;

	assign addr_ok = hsel && htrans[1] && hready;
	assign link.rom_boot_select_pin      = ctrl_q[CTRL_PIN];
	assign link.external_interrupt_two_n = external_interrupt_two_n_q;
	assign link.host_line_clear          = clear_q;
	assign link.mem_rdata                = rdata_q;
	assign link.mem_ack                  = ack_q;

	always_comb begin
		rd_mux = '0;
		if ((haddr[11:0] & IMAGE_MASK) == IMAGE_BASE) begin
			rd_mux = {16'h0000, image_q[haddr[7:2]]};
		end else begin
			case (haddr[11:0])
				REG_CTRL:     rd_mux = {28'h0000000, ctrl_q};
				REG_STATUS:   rd_mux = {24'h000000, link.boot_mode, 2'b00, link.boot_done, link.host_interrupt_line_n};
				REG_SELECT:   rd_mux = {24'h000000, select_q};
				REG_BRANCH:   rd_mux = {16'h0000, link.branch_addr};
				REG_PM_LAST:  rd_mux = pm_last_q;
				REG_PM_COUNT: rd_mux = {16'h0000, pm_count_q};
				default:      rd_mux = '0;
			endcase
		end
	end

	// Bus slave: read data latched at address phase, writes land at data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_addr_q <= haddr[11:0];
			end
			if (addr_ok && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q   <= CTRL_RESET;
			select_q <= '0;
			clear_q  <= 1'b0;
		end else begin
			clear_q <= 1'b0;
			if (wr_pend_q && wr_addr_q == REG_CTRL) begin
				ctrl_q  <= hwdata[3:0];
				clear_q <= hwdata[CTRL_CLEAR];
			end
			if (wr_pend_q && wr_addr_q == REG_SELECT) begin
				select_q <= hwdata[7:0];
			end
		end
	end

	// Image is loaded before the loader reads it
	always_ff @(posedge hclk) begin
		if (wr_pend_q && (wr_addr_q & IMAGE_MASK) == IMAGE_BASE) begin
			image_q[wr_addr_q[7:2]] <= hwdata[15:0];
		end
	end

	// Interrupt two: tied to the host line or raised by software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			external_interrupt_two_n_q <= 1'b1;
		end else if (ctrl_q[CTRL_TIE]) begin
			external_interrupt_two_n_q <= link.host_interrupt_line_n;
		end else begin
			external_interrupt_two_n_q <= !ctrl_q[CTRL_EXTERNAL_INTERRUPT_TWO];
		end
	end

	// Memory answers one cycle after each strobe
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_q      <= 1'b0;
			rdata_q    <= '0;
			pm_last_q  <= '0;
			pm_count_q <= '0;
		end else begin
			ack_q <= link.mem_rd;
			if (link.mem_rd) begin
				if (!link.io_space_strobe_n) begin
					rdata_q <= (link.mem_addr == SELECT_PORT) ? {8'h00, select_q} : 16'h0000;
				end else begin
					rdata_q <= image_q[link.mem_addr[5:0]];
				end
			end
			if (link.pm_we) begin
				pm_last_q  <= {link.pm_addr, link.pm_wdata};
				pm_count_q <= pm_count_q + 16'd1;
			end
		end
	end
endmodule

// ### sim/boot_link_monitor.sv
// Purpose: Concurrent checks on the link between boot loader and system end
// Assumes: One clock; every link signal comes from a flip-flop
// Notes:   Helper counters hold what the link history implies
`timescale 1ns/100ps
module boot_link_monitor (
	input wire logic            hclk,
	input wire logic            hresetn,
	input wire logic            host_interrupt_line_n,
	input wire logic            host_line_clear,
	input wire logic [15:0]     mem_addr,
	input wire logic            mem_rd,
	input wire logic            io_space_strobe_n,
	input wire logic [15:0]     mem_rdata,
	input wire logic            mem_ack,
	input wire logic [15:0]     pm_addr,
	input wire logic            pm_we,
	input wire logic            boot_done,
	input wire logic [15:0]     branch_addr,
	input wire boot_pkg::mode_t boot_mode
);
	import boot_pkg::*;
	logic [3:0]  gap_q;
	logic [15:0] last_pm_q;
	logic [15:0] first_pm_q;
	logic        seen_pm_q;
	logic [7:0]  sel_q;

	default clocking mon_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Saturates so a long stall never wraps back under the gap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			gap_q <= 4'h0;
		else if (mem_ack)
			gap_q <= 4'h0;
		else if (gap_q != 4'hf)
			gap_q <= gap_q + 4'h1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seen_pm_q <= 1'b0;
			last_pm_q <= 16'h0000;
			first_pm_q <= 16'h0000;
		end else if (pm_we) begin
			seen_pm_q <= 1'b1;
			last_pm_q <= pm_addr;
			if (!seen_pm_q)
				first_pm_q <= pm_addr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sel_q <= 8'h00;
		else if (mem_ack && !io_space_strobe_n)
			sel_q <= mem_rdata[7:0];
	end

	sel_port_a: assert property (!io_space_strobe_n && mem_rd |-> mem_addr == SELECT_PORT)
		else $error("select read away from the select port");
	src_page_a: assert property (mem_rd && io_space_strobe_n |-> mem_addr[15:10] == sel_q[7:2])
		else $error("source page differs from select word");
	copy_gap_a: assert property (pm_we |-> gap_q >= COPY_GAP_CYC)
		else $error("program write too soon after memory read");
	pm_step_a: assert property (pm_we && seen_pm_q |-> pm_addr == last_pm_q + 16'h0001)
		else $error("program address did not step by one");
	branch_dest_a: assert property ($rose(boot_done) && (boot_mode == MODE_PAR8 || boot_mode == MODE_PAR16)
		|-> branch_addr == first_pm_q)
		else $error("branch differs from first destination");
	host_branch_a: assert property (boot_done && boot_mode == MODE_HOST |-> branch_addr == HOST_RAM_START)
		else $error("host boot branch address wrong");
	warm_branch_a: assert property ($rose(boot_done) && boot_mode == MODE_WARM
		|-> branch_addr == {sel_q[7:2], 10'h000})
		else $error("warm boot branch address wrong");
	host_hold_a: assert property (!host_interrupt_line_n && !host_line_clear |=> !host_interrupt_line_n)
		else $error("host line released without clear");
	host_release_a: assert property (host_line_clear && !host_interrupt_line_n |-> ##[1:2] host_interrupt_line_n)
		else $error("host line not released after clear");
	host_wait_a: assert property ($fell(host_interrupt_line_n) |->
		(!boot_done && io_space_strobe_n)[*8] ##1 (!boot_done && io_space_strobe_n)[*8]
		##1 (!boot_done && io_space_strobe_n)[*4])
		else $error("host flag tested too early");
	cover property (boot_done && boot_mode == MODE_PAR8);
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench for the boot loader and its system end
// Assumes: Image and select word are written while the loader is still held in reset
// Notes:   Every boot run begins with its own reset
`timescale 1ns/100ps
module testbench;
	import boot_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        core_resetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'b010;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        global_int_mask;
	logic        ram_overlay;
	logic [15:0] wait_state_cfg;
	logic [15:0] bank_cfg;
	logic        shared_access_select;
	logic        serial_word16;
	logic        serial_clk_out;
	logic        serial_port_tdm;
	logic [15:0] pm_a [$];
	logic [15:0] pm_d [$];
	logic [31:0] rd;
	int          n_mismatch = 0;
	int          comparisons = 0;

	boot_link_if link ();
	boot_mode_loader u_boot_mode_loader (.hclk(hclk), .hresetn(core_resetn), .link(link),
		.global_int_mask(global_int_mask), .ram_overlay(ram_overlay), .wait_state_cfg(wait_state_cfg),
		.bank_cfg(bank_cfg), .shared_access_select(shared_access_select), .serial_word16(serial_word16),
		.serial_clk_out(serial_clk_out), .serial_port_tdm(serial_port_tdm));
	boot_system_end u_boot_system_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
	boot_link_monitor u_boot_link_monitor (.hclk(hclk), .hresetn(core_resetn),
		.host_interrupt_line_n(link.host_interrupt_line_n), .host_line_clear(link.host_line_clear),
		.mem_addr(link.mem_addr), .mem_rd(link.mem_rd), .io_space_strobe_n(link.io_space_strobe_n),
		.mem_rdata(link.mem_rdata), .mem_ack(link.mem_ack), .pm_addr(link.pm_addr), .pm_we(link.pm_we),
		.boot_done(link.boot_done), .branch_addr(link.branch_addr), .boot_mode(link.boot_mode));

	always #2.5 hclk = ~hclk;

	// Record every program memory write as it happens
	always @(posedge hclk) begin
		if (link.pm_we === 1'b1) begin
			pm_a.push_back(link.pm_addr);
			pm_d.push_back(link.pm_wdata);
		end
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {20'h00000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	// Image is destination, length n-1, then n code words; byte mode puts junk above bit 7
	task automatic boot(input logic [3:0] ctl, input logic [15:0] sel, input logic [15:0] dest,
		input logic [63:0] code, input int n, input logic byte_mode);
		logic [15:0] w;
		int          i;
		// Loader leaves reset only once its image and select word are in place
		@(posedge hclk);
		hresetn     <= 1'b0;
		core_resetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		pm_a.delete();
		pm_d.delete();
		bus(1'b1, REG_CTRL, {28'h0, ctl});
		bus(1'b1, REG_SELECT, {16'h0, sel});
		for (i = 0; i < n + 2; i++) begin
			w = (i == 0) ? dest : (i == 1) ? 16'(n - 1) : code[16 * (n + 1 - i) +: 16];
			if (byte_mode) begin
				bus(1'b1, IMAGE_BASE + 12'(8 * i), {24'h0000c3, w[15:8]});
				bus(1'b1, IMAGE_BASE + 12'(8 * i + 4), {24'h0000c3, w[7:0]});
			end else
				bus(1'b1, IMAGE_BASE + 12'(4 * i), {16'h0, w});
		end
		core_resetn <= 1'b1;
		bus(1'b0, REG_BRANCH, 32'h0);
		check(rd[15:0], ctl[CTRL_PIN] ? EXT_RESET_VECTOR : ROM_BOOT_ENTRY);
		i = 0;
		while (link.boot_done !== 1'b1 && i < 3000) begin
			@(posedge hclk);
			i++;
		end
		check(link.boot_done, 1'b1);
	endtask

	task automatic copy_check(input mode_t m, input logic [15:0] dest, input logic [63:0] code, input int n);
		int i;
		check(pm_a.size(), n);
		for (i = 0; i < n && i < pm_a.size(); i++) begin
			check(pm_a[i], dest + 16'(i));
			check(pm_d[i], code[16 * (n - 1 - i) +: 16]);
		end
		bus(1'b0, REG_BRANCH, 32'h0);
		check(rd[15:0], dest);
		check(hresp, 1'b0);
		bus(1'b0, REG_PM_COUNT, 32'h0);
		check(rd[15:0], 16'(n));
		bus(1'b0, REG_STATUS, 32'h0);
		check(rd[7:4], m);
		$display("test copy of %0d words done", n);
	endtask

	initial begin
		logic [7:0] sels [0:8];
		mode_t      modes [0:8];
		int         i;
		sels = '{8'h08, 8'h0c, 8'h00, 8'h04, 8'h10, 8'h14, 8'h20, 8'h24, 8'hcb};
		modes = '{MODE_IO16, MODE_IO8, MODE_BSP8_OUT, MODE_BSP16_OUT, MODE_BSP8_IN,
			MODE_BSP16_IN, MODE_TDM8_OUT, MODE_TDM16_OUT, MODE_WARM};
		// Junk in the upper select byte must not change the mode
		boot(4'h0, 16'ha506, 16'h2340, 64'hbeef_1234_c0de, 3, 1'b0);
		copy_check(MODE_PAR16, 16'h2340, 64'hbeef_1234_c0de, 3);
		check({global_int_mask, ram_overlay}, 2'b11);
		check({wait_state_cfg, bank_cfg}, {WAIT_STATE_CFG, BANK_CFG});
		check(shared_access_select, 1'b1);
		bus(1'b0, 12'h0f0, 32'h0);
		check(rd, 32'h0);
		boot(4'h0, 16'h0002, 16'h0300, 64'h5a5a, 1, 1'b0);
		copy_check(MODE_PAR16, 16'h0300, 64'h5a5a, 1);
		boot(4'h0, 16'h0005, 16'h0810, 64'hbeef_1234, 2, 1'b1);
		copy_check(MODE_PAR8, 16'h0810, 64'hbeef_1234, 2);
		for (i = 0; i < 9; i++) begin
			boot(4'h0, {8'h3c, sels[i]}, 16'h0, 64'h0, 0, 1'b0);
			bus(1'b0, REG_STATUS, 32'h0);
			check(rd[7:4], modes[i]);
			if (i > 1 && i < 8)
				check({serial_word16, serial_clk_out, serial_port_tdm}, {sels[i][2], ~sels[i][4], sels[i][5]});
		end
		bus(1'b0, REG_BRANCH, 32'h0);
		check(rd[15:0], 16'hc800);
		$display("test select decode done");
		boot(4'h2, 16'h0006, 16'h0, 64'h0, 0, 1'b0);
		bus(1'b0, REG_BRANCH, 32'h0);
		check(rd[15:0], HOST_RAM_START);
		check(pm_a.size(), 0);
		bus(1'b0, REG_STATUS, 32'h0);
		check(rd[0], 1'b0);
		bus(1'b1, REG_CTRL, 32'h4);
		bus(1'b0, REG_STATUS, 32'h0);
		check(rd[0], 1'b1);
		boot(4'h8, 16'h0006, 16'h0, 64'h0, 0, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0);
		check(rd[7:4], MODE_HOST);
		$display("test host boot done");
		boot(4'h1, 16'h0006, 16'h0, 64'h0, 0, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0);
		check(rd[7:4], MODE_EXT);
		check(global_int_mask, 1'b0);
		$display("test external start done");
		final_report();
	end

	// About fifteen boot runs of under two hundred cycles each; ten thousand cycles is ample
	initial begin
		#50000;
		n_mismatch++;
		final_report();
	end
endmodule
